// ---- core/ssi_consts.svh ----
`ifndef SSI_CONSTS_SVH
`define SSI_CONSTS_SVH
// Contract
// - serial clock control is 4-bit write-only, clears to zero on reset
// - clock control write stops serial clock, clears bit counter to 000
// - clock control write during transfer aborts it and sets irq flag
// - new clock control value acts two cycles after the write
// - control bit 3 picks final divide 2 or 4 for prescaler clocks
// - bits 2..0 pick prescaler tap, system clock, or external clock input
// - idle/pin control is 2-bit write-only, writes ignored during transfer
// - idle/pin bit 2 drives data pin pull-up, only it resets to 0
// - idle/pin bit 1 sets idle data output level at once
// - transmit data leaves LSB first, changing on falling serial clock
// - data input sampled on rising serial clock, shifted in LSB first
// - shift register is two 4-bit read/write halves, no reset value
// - pin select is 4-bit write-only, clears to zero on reset
// - module standby is write-only, gates block clock, clears on reset
// - pin select 0x1 continuous clock, 101 receive, 111 transmit
// - start clears counter; rising edges count; eighth ends transfer, sets irq
// - internal clock stops after eight pulses

// register indices; byte address is four times the index
`define SSI_IDX_PIN_SEL 6'h0b
`define SSI_IDX_STANDBY 6'h0e
`define SSI_IDX_CLK_CTRL 6'h24
`define SSI_IDX_IDLE_PIN 6'h25
`define SSI_IDX_DATA_LO 6'h26
`define SSI_IDX_DATA_HI 6'h27
`define SSI_IDX_START 6'h30
`define SSI_IDX_STATUS 6'h31

`define SSI_RST_CLK_CTRL 4'h0
`define SSI_RST_PIN_SEL 4'h0
`define SSI_RST_STANDBY 4'h0
`define SSI_CODE_SYSCLK 3'h6
`define SSI_CODE_EXT 3'h7
`define SSI_CTRL_DELAY 2'h2
`define SSI_LAST_BIT 3'h7
`define SSI_RESP_OKAY 2'h0
`define SSI_RESP_DECERR 2'h3
`endif

// ---- core/ssi_pkg.sv ----
package ssi_pkg;
  typedef enum logic [1:0] {
    SSI_ST_IDLE,
    SSI_ST_WAIT,
    SSI_ST_XFER,
    SSI_ST_CONT
  } ssi_state_t;
endpackage

// ---- core/ssi_top.sv ----
// Design decision made here: the AXI4-Lite register port.
`timescale 1ns/1ns
`include "ssi_consts.svh"
module ssi_top (
  input wire logic aclk, // 20 MHz
  input wire logic aresetn, // sync reset
  input wire logic [7:0] s_axi_awaddr, // write address
  input wire logic s_axi_awvalid, // write address valid
  output logic s_axi_awready, // write address ready
  input wire logic [31:0] s_axi_wdata, // write data
  input wire logic [3:0] s_axi_wstrb, // byte enables
  input wire logic s_axi_wvalid, // write data valid
  output logic s_axi_wready, // write data ready
  output logic [1:0] s_axi_bresp, // write response
  output logic s_axi_bvalid, // write response valid
  input wire logic s_axi_bready, // write response ready
  input wire logic [7:0] s_axi_araddr, // read address
  input wire logic s_axi_arvalid, // read address valid
  output logic s_axi_arready, // read address ready
  output logic [31:0] s_axi_rdata, // read data
  output logic [1:0] s_axi_rresp, // read response
  output logic s_axi_rvalid, // read data valid
  input wire logic s_axi_rready, // read data ready
  input wire logic sck_in, // serial clock pin level
  output logic sck_out, // serial clock drive
  output logic sck_oe, // serial clock drive enable
  input wire logic sdata_in, // data pin level
  output logic sdata_out, // data pin drive
  output logic sdata_oe, // data pin drive enable
  output logic sdata_pullup_en, // data pin pull-up on
  output ssi_pkg::ssi_state_t serial_state // interface state
);
  import ssi_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  logic aw_full_reg, aw_full_next, w_full_reg, w_full_next;
  logic [5:0] aw_idx_reg, aw_idx_next;
  logic [3:0] wdata_reg, wdata_next;
  logic wstrb_reg, wstrb_next;
  logic bvalid_reg, bvalid_next, rvalid_reg, rvalid_next;
  logic [1:0] bresp_reg, bresp_next, rresp_reg, rresp_next;
  logic [31:0] rdata_reg, rdata_next;
  logic wr_fire, wr_ok, wr_hit;
  logic ctrl_wr, sts_wr, idle_wr, stat_wr;
  logic [3:0] rd_val;
  logic rd_hit;

  assign wr_fire = aw_full_reg & w_full_reg & ~bvalid_reg;
  assign wr_ok = wr_fire & wstrb_reg;
  assign ctrl_wr = wr_ok & (aw_idx_reg == `SSI_IDX_CLK_CTRL);
  assign sts_wr = wr_ok & (aw_idx_reg == `SSI_IDX_START) & wdata_reg[0];
  assign idle_wr = wr_ok & (aw_idx_reg == `SSI_IDX_IDLE_PIN);
  assign stat_wr = wr_ok & (aw_idx_reg == `SSI_IDX_STATUS) & wdata_reg[0];
  assign s_axi_awready = ~aw_full_reg;
  assign s_axi_wready = ~w_full_reg;
  assign s_axi_arready = ~rvalid_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rresp = rresp_reg;
  assign s_axi_rdata = rdata_reg;

  always_comb begin
    case (aw_idx_reg)
      `SSI_IDX_PIN_SEL, `SSI_IDX_STANDBY, `SSI_IDX_CLK_CTRL, `SSI_IDX_IDLE_PIN,
      `SSI_IDX_DATA_LO, `SSI_IDX_DATA_HI, `SSI_IDX_START, `SSI_IDX_STATUS: wr_hit = 1'b1;
      default: wr_hit = 1'b0;
    endcase
  end

  always_comb begin
    aw_full_next = aw_full_reg;
    w_full_next = w_full_reg;
    aw_idx_next = aw_idx_reg;
    wdata_next = wdata_reg;
    wstrb_next = wstrb_reg;
    bvalid_next = bvalid_reg;
    bresp_next = bresp_reg;
    rvalid_next = rvalid_reg;
    rresp_next = rresp_reg;
    rdata_next = rdata_reg;
    if (s_axi_awvalid && !aw_full_reg) begin
      aw_full_next = 1'b1;
      aw_idx_next = s_axi_awaddr[7:2];
    end
    if (s_axi_wvalid && !w_full_reg) begin
      w_full_next = 1'b1;
      wdata_next = s_axi_wdata[3:0];
      wstrb_next = s_axi_wstrb[0];
    end
    if (wr_fire) begin
      aw_full_next = 1'b0;
      w_full_next = 1'b0;
      bvalid_next = 1'b1;
      bresp_next = wr_hit ? `SSI_RESP_OKAY : `SSI_RESP_DECERR;
    end
    if (bvalid_reg && s_axi_bready) begin
      bvalid_next = 1'b0;
    end
    if (s_axi_arvalid && !rvalid_reg) begin
      rvalid_next = 1'b1;
      rdata_next = {28'h0000000, rd_val};
      rresp_next = rd_hit ? `SSI_RESP_OKAY : `SSI_RESP_DECERR;
    end else if (rvalid_reg && s_axi_rready) begin
      rvalid_next = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_reg <= 1'b0;
      w_full_reg <= 1'b0;
      aw_idx_reg <= 6'h00;
      wdata_reg <= 4'h0;
      wstrb_reg <= 1'b0;
      bvalid_reg <= 1'b0;
      bresp_reg <= 2'h0;
      rvalid_reg <= 1'b0;
      rresp_reg <= 2'h0;
      rdata_reg <= 32'h00000000;
    end else begin
      aw_full_reg <= aw_full_next;
      w_full_reg <= w_full_next;
      aw_idx_reg <= aw_idx_next;
      wdata_reg <= wdata_next;
      wstrb_reg <= wstrb_next;
      bvalid_reg <= bvalid_next;
      bresp_reg <= bresp_next;
      rvalid_reg <= rvalid_next;
      rresp_reg <= rresp_next;
      rdata_reg <= rdata_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  logic [3:0] pin_sel_reg, pin_sel_next, standby_reg, standby_next;
  logic [3:0] clk_ctrl_reg, clk_ctrl_next, eff_reg, eff_next;
  logic [1:0] dly_reg, dly_next;
  logic pull_reg, pull_next;
  ssi_state_t state_reg, state_next;

  always_comb begin
    pin_sel_next = pin_sel_reg;
    standby_next = standby_reg;
    clk_ctrl_next = clk_ctrl_reg;
    eff_next = eff_reg;
    dly_next = dly_reg;
    pull_next = pull_reg;
    if (wr_ok && aw_idx_reg == `SSI_IDX_PIN_SEL) begin
      pin_sel_next = wdata_reg;
    end
    if (wr_ok && aw_idx_reg == `SSI_IDX_STANDBY) begin
      standby_next = wdata_reg;
    end
    if (dly_reg != 2'h0) begin
      dly_next = dly_reg - 2'h1;
      if (dly_reg == 2'h1) begin
        eff_next = clk_ctrl_reg;
      end
    end
    if (ctrl_wr) begin
      clk_ctrl_next = wdata_reg;
      dly_next = `SSI_CTRL_DELAY;
    end
    if (idle_wr && state_reg != SSI_ST_XFER) begin
      pull_next = wdata_reg[2];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_sel_reg <= `SSI_RST_PIN_SEL;
      standby_reg <= `SSI_RST_STANDBY;
      clk_ctrl_reg <= `SSI_RST_CLK_CTRL;
      eff_reg <= `SSI_RST_CLK_CTRL;
      dly_reg <= 2'h0;
      pull_reg <= 1'b0;
    end else begin
      pin_sel_reg <= pin_sel_next;
      standby_reg <= standby_next;
      clk_ctrl_reg <= clk_ctrl_next;
      eff_reg <= eff_next;
      dly_reg <= dly_next;
      pull_reg <= pull_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  logic [10:0] presc_reg, presc_next, tap_mask;
  logic half_reg, half_next, sck_reg, sck_next;
  logic [2:0] cnt_reg, cnt_next;
  logic [7:0] sr_reg, sr_next;
  logic so_reg, so_next, irq_reg, irq_next;
  logic sck_s1, sck_s2, sck_s3, si_s1, si_s2;
  logic run, internal, gen_on, tick, toggle, fall_ev, rise_ev, cont_mode, tx_mode;

  // standby bit 0 stops the block clock
  assign run = ~standby_reg[0];
  assign internal = eff_reg[2:0] != `SSI_CODE_EXT;
  assign cont_mode = ~pin_sel_reg[3] & pin_sel_reg[1];
  assign tx_mode = pin_sel_reg[3] & pin_sel_reg[2] & pin_sel_reg[1];
  // tap select: /2048 down to /2, system clock every cycle
  assign tap_mask = (eff_reg[2:0] >= `SSI_CODE_SYSCLK) ? 11'h000 :
                    (11'h7ff >> {eff_reg[2:0], 1'b0});
  assign tick = (presc_reg & tap_mask) == tap_mask;
  assign gen_on = run & internal & ~ctrl_wr & (state_reg != SSI_ST_IDLE);
  // divide 2 toggles every tick, divide 4 every other tick
  assign toggle = gen_on & tick & (~eff_reg[3] | half_reg);
  assign fall_ev = internal ? (toggle & sck_reg) :
                   (run & ~ctrl_wr & sck_s3 & ~sck_s2 & state_reg != SSI_ST_IDLE);
  assign rise_ev = internal ? (toggle & ~sck_reg) :
                   (run & ~ctrl_wr & ~sck_s3 & sck_s2 & state_reg != SSI_ST_IDLE);

  always_comb begin
    presc_next = presc_reg;
    half_next = half_reg;
    sck_next = sck_reg;
    cnt_next = cnt_reg;
    sr_next = sr_reg;
    so_next = so_reg;
    irq_next = irq_reg;
    state_next = state_reg;
    if (run) begin
      presc_next = presc_reg + 11'h001;
    end
    if (gen_on && tick) begin
      half_next = ~half_reg;
    end
    if (toggle) begin
      sck_next = ~sck_reg;
    end
    if (stat_wr) begin
      irq_next = 1'b0;
    end
    if (ctrl_wr) begin
      cnt_next = 3'h0;
      sck_next = 1'b1;
      half_next = 1'b0;
      if (state_reg == SSI_ST_XFER) begin
        irq_next = 1'b1;
      end
      state_next = SSI_ST_IDLE;
    end else if (sts_wr) begin
      cnt_next = 3'h0;
      if (state_reg == SSI_ST_XFER) begin
        irq_next = 1'b1;
      end
      state_next = SSI_ST_WAIT;
    end else begin
      unique case (state_reg)
        SSI_ST_IDLE: begin
          sck_next = 1'b1;
        end
        SSI_ST_WAIT: begin
          if (fall_ev) begin
            if (cont_mode && internal) begin
              state_next = SSI_ST_CONT;
            end else begin
              state_next = SSI_ST_XFER;
              so_next = sr_reg[0];
            end
          end
        end
        SSI_ST_XFER: begin
          if (fall_ev) begin
            so_next = sr_reg[0];
          end
          // sample on rising edge, LSB first
          if (rise_ev) begin
            sr_next = {si_s2, sr_reg[7:1]};
            cnt_next = cnt_reg + 3'h1;
            if (cnt_reg == `SSI_LAST_BIT) begin
              irq_next = 1'b1;
              state_next = internal ? SSI_ST_IDLE : SSI_ST_WAIT;
            end
          end
        end
        SSI_ST_CONT: begin
        end
      endcase
    end
    if (wr_ok && aw_idx_reg == `SSI_IDX_DATA_LO) begin
      sr_next[3:0] = wdata_reg;
    end
    if (wr_ok && aw_idx_reg == `SSI_IDX_DATA_HI) begin
      sr_next[7:4] = wdata_reg;
    end
    // idle level follows the write at once
    if (idle_wr && state_reg != SSI_ST_XFER) begin
      so_next = wdata_reg[1];
    end
  end

  // shift data and idle level carry no reset value
  always_ff @(posedge aclk) begin
    sr_reg <= sr_next;
    so_reg <= so_next;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      presc_reg <= 11'h000;
      half_reg <= 1'b0;
      sck_reg <= 1'b1;
      cnt_reg <= 3'h0;
      irq_reg <= 1'b0;
      state_reg <= SSI_ST_IDLE;
      sck_s1 <= 1'b1;
      sck_s2 <= 1'b1;
      sck_s3 <= 1'b1;
      si_s1 <= 1'b0;
      si_s2 <= 1'b0;
    end else begin
      presc_reg <= presc_next;
      half_reg <= half_next;
      sck_reg <= sck_next;
      cnt_reg <= cnt_next;
      irq_reg <= irq_next;
      state_reg <= state_next;
      sck_s1 <= sck_in;
      sck_s2 <= sck_s1;
      sck_s3 <= sck_s2;
      si_s1 <= sdata_in;
      si_s2 <= si_s1;
    end
  end

  always_comb begin
    rd_hit = 1'b1;
    unique case (s_axi_araddr[7:2])
      `SSI_IDX_DATA_LO: rd_val = sr_reg[3:0];
      `SSI_IDX_DATA_HI: rd_val = sr_reg[7:4];
      `SSI_IDX_STATUS: rd_val = {state_reg, 1'b0, irq_reg};
      `SSI_IDX_PIN_SEL, `SSI_IDX_STANDBY, `SSI_IDX_CLK_CTRL, `SSI_IDX_IDLE_PIN,
      `SSI_IDX_START: rd_val = 4'h0;
      default: begin
        rd_val = 4'h0;
        rd_hit = 1'b0;
      end
    endcase
  end

  assign sck_out = sck_reg;
  assign sck_oe = pin_sel_reg[1] & internal;
  assign sdata_oe = tx_mode;
  assign sdata_out = tx_mode & so_reg;
  assign sdata_pullup_en = pull_reg;
  assign serial_state = state_reg;

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_ctrl_hold;
    ctrl_wr ##1 !ctrl_wr ##1 !ctrl_wr;
  endsequence

  reset_clear_a: assert property ($rose(aresetn) |->
    clk_ctrl_reg == 4'h0 && pin_sel_reg == 4'h0 && standby_reg == 4'h0 && !pull_reg)
    else $error("control registers not cleared by reset");
  ctrl_clear_a: assert property (ctrl_wr |=> cnt_reg == 3'h0 && sck_reg)
    else $error("clock control write did not clear counter");
  ctrl_abort_a: assert property (ctrl_wr && state_reg == SSI_ST_XFER |=>
    irq_reg && state_reg == SSI_ST_IDLE)
    else $error("abort did not set flag");
  ctrl_delay_a: assert property (s_ctrl_hold |=> eff_reg == clk_ctrl_reg)
    else $error("clock control not taken over in time");
  ctrl_early_a: assert property (ctrl_wr |=> ##1 eff_reg == $past(eff_reg, 2))
    else $error("clock control took effect too early");
  idle_lock_a: assert property (idle_wr && state_reg == SSI_ST_XFER |=>
    $stable(pull_reg))
    else $error("idle control changed during transfer");
  idle_level_a: assert property (idle_wr && state_reg != SSI_ST_XFER |=>
    so_reg == $past(wdata_reg[1]) && pull_reg == $past(wdata_reg[2]))
    else $error("idle level not applied");
  tx_lsb_a: assert property (state_reg == SSI_ST_XFER && fall_ev && !sts_wr && !ctrl_wr
    |=> so_reg == $past(sr_reg[0]))
    else $error("output bit not LSB");
  rx_shift_a: assert property (state_reg == SSI_ST_XFER && rise_ev && !sts_wr && !ctrl_wr
    |=> sr_reg[7] == $past(si_s2) && sr_reg[6:0] == $past(sr_reg[7:1]))
    else $error("input bit not shifted in");
  xfer_end_a: assert property (state_reg == SSI_ST_XFER && rise_ev && cnt_reg == 3'h7
    && !sts_wr && !ctrl_wr |=> irq_reg && cnt_reg == 3'h0 && state_reg != SSI_ST_XFER)
    else $error("transfer did not end on eighth edge");
  int_stop_a: assert property (state_reg == SSI_ST_IDLE && !sts_wr |=> sck_reg)
    else $error("internal clock ran after transfer");
  cont_mode_a: assert property (state_reg == SSI_ST_WAIT && fall_ev && cont_mode
    && internal && !sts_wr && !ctrl_wr |=> state_reg == SSI_ST_CONT)
    else $error("continuous mode not entered");
  standby_a: assert property (standby_reg[0] |-> !toggle && !rise_ev)
    else $error("serial clock ran in standby");
endmodule

// ---- bench/ssi_serial_peer.sv ----
`timescale 1ns/1ns
module ssi_serial_peer (
  input wire logic aclk, // bench clock
  input wire logic sck_pin, // resolved serial clock line
  input wire logic data_pin, // resolved data line
  input wire logic [7:0] tx_byte, // byte to send back
  input wire logic go, // start eight external clock pulses
  input wire logic [7:0] half, // half period in aclk cycles
  output logic sck_drive, // external clock, still and high outside frames
  output logic data_drive, // bit offered on the data line
  output logic [7:0] rx_byte, // bits caught, first one ends in bit 0
  output logic [7:0] n_rise, // rising clock edges seen
  output logic [15:0] period // aclk cycles between the last two rises
);
  logic sck_d;
  logic [15:0] since;
  logic [2:0] txi;
  logic [7:0] hc;
  logic [4:0] edges;
  initial begin
    {sck_d, sck_drive} = 2'b11;
    {since, txi, hc, edges, data_drive, rx_byte, n_rise, period} = '0;
  end
  ////////////////////////////////////////////////////////////////
  always @(posedge aclk) begin
    sck_d <= sck_pin;
    since <= since + 16'h1;
    if (sck_pin && !sck_d) begin
      rx_byte <= {data_pin, rx_byte[7:1]};
      n_rise <= n_rise + 8'h1;
      period <= since + 16'h1;
      since <= 16'h0;
    end
    if (!sck_pin && sck_d) begin
      data_drive <= tx_byte[txi];
      txi <= txi + 3'h1;
    end
    // slow or prompt clock, sixteen half periods, ends high
    if (go) begin
      edges <= 5'd16;
      hc <= 8'h0;
      txi <= 3'h0;
    end else if (edges != 5'd0) begin
      if (hc == half - 8'h1) begin
        hc <= 8'h0;
        sck_drive <= ~sck_drive;
        edges <= edges - 5'd1;
      end else begin
        hc <= hc + 8'h1;
      end
    end
  end
endmodule

// ---- bench/sync_serial_interface_regs_tb.sv ----
`timescale 1ns/1ns
`include "ssi_consts.svh"
module sync_serial_interface_regs_tb;
  import ssi_pkg::*;
  typedef struct {logic [7:0] a; logic [31:0] d; logic [31:0] q; logic [1:0] r;} ssi_row_t;
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, sck_out, sck_oe, sdata_out, sdata_oe, pull_en;
  logic peer_sck, peer_dat, peer_en, go, alt, sck_pin, data_pin;
  logic [7:0] awaddr, araddr, n_rise, tx_byte, rx_byte, half, n0;
  logic [31:0] wdata, rdata, v;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, resp;
  logic [15:0] period;
  ssi_state_t st;
  ssi_row_t rows [7];
  logic [3:0] cc [4];
  logic [7:0] txs [4];
  logic [31:0] pp [4];
  int n_fail, checked, i, k;
  ssi_top DUT (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .sck_in(sck_pin), .sck_out(sck_out), .sck_oe(sck_oe),
    .sdata_in(data_pin), .sdata_out(sdata_out), .sdata_oe(sdata_oe),
    .sdata_pullup_en(pull_en), .serial_state(st));
  ssi_serial_peer peer (.aclk(aclk), .sck_pin(sck_pin), .data_pin(data_pin),
    .tx_byte(tx_byte), .go(go), .half(half), .sck_drive(peer_sck),
    .data_drive(peer_dat), .rx_byte(rx_byte), .n_rise(n_rise), .period(period));
  // released data line floats: model it as a toggling level unless pulled up
  assign sck_pin = sck_oe ? sck_out : peer_sck;
  assign data_pin = sdata_oe ? sdata_out : peer_en ? peer_dat : pull_en ? 1'b1 : alt;
  initial begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end
  always @(posedge aclk) alt <= ~alt;
  ////////////////////////////////////////////////////////////////
  task automatic end_sim;
    $display("mismatches=%0d comparisons=%0d", n_fail, checked);
    if (n_fail == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) begin
      n_fail++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic hang;
    n_fail++;
    end_sim();
  endtask
  function automatic logic [7:0] ad(input logic [5:0] x);
    return {x, 2'b00};
  endfunction
  // each bus task ends with an idle edge so no strobe is set twice in one step
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int j;
    awaddr <= a;
    wdata <= d;
    {awvalid, wvalid, bready} <= 3'b111;
    for (j = 0; j < 99; j++) begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid === 1'b1) break;
    end
    if (j == 99) hang();
    resp = bresp;
    bready <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic rd(input logic [7:0] a);
    int j;
    araddr <= a;
    {arvalid, rready} <= 2'b11;
    for (j = 0; j < 99; j++) begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid === 1'b1) break;
    end
    if (j == 99) hang();
    v = rdata;
    resp = rresp;
    rready <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic wait_flag;
    int j;
    for (j = 0; j < 3000; j++) begin
      rd(ad(`SSI_IDX_STATUS));
      if (v[0] === 1'b1) break;
    end
    if (j == 3000) hang();
  endtask
  task automatic start_after_ctrl(input logic [31:0] c);
    wr(ad(`SSI_IDX_CLK_CTRL), c);
    repeat (3) @(posedge aclk);
    n0 = n_rise;
    wr(ad(`SSI_IDX_START), 32'h1);
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, peer_en, go, alt} = '0;
    {awaddr, araddr, wdata} = '0;
    wstrb = 4'hf;
    half = 8'h5;
    tx_byte = 8'h3c;
    n_fail = 0;
    checked = 0;
    // halves read back; write-only places read zero; unmapped refused
    rows[0] = '{ad(`SSI_IDX_DATA_LO), 32'h0a, 32'h0a, `SSI_RESP_OKAY};
    rows[1] = '{ad(`SSI_IDX_DATA_HI), 32'h05, 32'h05, `SSI_RESP_OKAY};
    rows[2] = '{ad(`SSI_IDX_CLK_CTRL), 32'h08, 32'h00, `SSI_RESP_OKAY};
    rows[3] = '{ad(`SSI_IDX_PIN_SEL), 32'h01, 32'h00, `SSI_RESP_OKAY};
    rows[4] = '{ad(`SSI_IDX_STANDBY), 32'h00, 32'h00, `SSI_RESP_OKAY};
    rows[5] = '{ad(`SSI_IDX_IDLE_PIN), 32'h04, 32'h00, `SSI_RESP_OKAY};
    rows[6] = '{8'hfc, 32'h01, 32'h00, `SSI_RESP_DECERR};
    cc = '{4'h5, 4'hd, 4'h4, 4'h6};
    pp = '{32'd4, 32'd8, 32'd16, 32'd2};
    txs = '{8'ha5, 8'h81, 8'h7e, 8'h3c};
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk(sck_oe, 1'b0);
    chk(pull_en, 1'b0);
    chk(st, SSI_ST_IDLE);
    rd(ad(`SSI_IDX_STATUS));
    chk(v, 32'h0);
    foreach (rows[r]) begin
      wr(rows[r].a, rows[r].d);
      chk(resp, rows[r].r);
      rd(rows[r].a);
      chk(resp, rows[r].r);
      if (rows[r].r == `SSI_RESP_OKAY) chk(32'(v[3:0]), rows[r].q);
    end
    wr(ad(`SSI_IDX_PIN_SEL), 32'he);
    wr(ad(`SSI_IDX_IDLE_PIN), 32'h6);
    chk(pull_en, 1'b1);
    chk(sdata_out, 1'b1);
    wr(ad(`SSI_IDX_IDLE_PIN), 32'h4);
    chk(sdata_out, 1'b0);
    for (k = 0; k < 4; k++) begin
      wr(ad(`SSI_IDX_DATA_LO), 32'(txs[k][3:0]));
      wr(ad(`SSI_IDX_DATA_HI), 32'(txs[k][7:4]));
      start_after_ctrl(32'(cc[k]));
      wait_flag();
      chk(v, 32'h1);
      chk(rx_byte, txs[k]);
      chk(8'(n_rise - n0), 32'd8);
      chk(period, pp[k]);
      repeat (40) @(posedge aclk);
      chk(8'(n_rise - n0), 32'd8);
      chk(sck_out, 1'b1);
      wr(ad(`SSI_IDX_STATUS), 32'h1);
    end
    // external clock, receive mode, slow far side
    wr(ad(`SSI_IDX_PIN_SEL), 32'ha);
    peer_en <= 1'b1;
    start_after_ctrl(32'h7);
    chk(sck_oe, 1'b0);
    go <= 1'b1;
    @(posedge aclk);
    go <= 1'b0;
    wait_flag();
    chk(v, 32'h5);
    // data read only once the transfer is over
    rd(ad(`SSI_IDX_DATA_LO));
    chk(32'(v[3:0]), 32'hc);
    rd(ad(`SSI_IDX_DATA_HI));
    chk(32'(v[3:0]), 32'h3);
    peer_en <= 1'b0;
    wr(ad(`SSI_IDX_STATUS), 32'h1);
    // abort in mid transfer
    wr(ad(`SSI_IDX_PIN_SEL), 32'he);
    wr(ad(`SSI_IDX_IDLE_PIN), 32'h6);
    start_after_ctrl(32'h4);
    for (i = 0; i < 200 && st !== SSI_ST_XFER; i++) @(posedge aclk);
    if (i == 200) hang();
    wr(ad(`SSI_IDX_IDLE_PIN), 32'h0);
    chk(pull_en, 1'b1);
    wr(ad(`SSI_IDX_CLK_CTRL), 32'h4);
    chk(st, SSI_ST_IDLE);
    n0 = n_rise;
    rd(ad(`SSI_IDX_STATUS));
    chk(v, 32'h1);
    repeat (40) @(posedge aclk);
    chk(8'(n_rise - n0), 32'd0);
    // standby freezes a started transfer until released
    wr(ad(`SSI_IDX_STATUS), 32'h1);
    wr(ad(`SSI_IDX_STANDBY), 32'h1);
    start_after_ctrl(32'h5);
    repeat (40) @(posedge aclk);
    chk(8'(n_rise - n0), 32'd0);
    chk(st, SSI_ST_WAIT);
    wr(ad(`SSI_IDX_STANDBY), 32'h0);
    wait_flag();
    chk(v, 32'h1);
    chk(sdata_oe, 1'b1);
    // continuous clock mode keeps pulsing past eight
    wr(ad(`SSI_IDX_PIN_SEL), 32'h2);
    start_after_ctrl(32'h5);
    repeat (60) @(posedge aclk);
    chk(st, SSI_ST_CONT);
    chk(32'(8'(n_rise - n0) > 8'd8), 32'h1);
    wr(ad(`SSI_IDX_CLK_CTRL), 32'h5);
    chk(st, SSI_ST_IDLE);
    end_sim();
  end
endmodule
